// ### dv/test_vtlb.sv
// self-checking bench for the video timing flag and lower bus block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module test_vtlb;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic emb = 1'b0, proc = 1'b0, rate = 1'b0, width = 1'b0, vproc = 1'b0, asy = 1'b0;
  logic src_valid, src_ready, fb, lb, fl, out_valid, lb_en, fw_ext, stuck;
  logic [9:0] up, lo;
  logic out_ready = 1'b0;
  vtlb_pkg::vtlb_word_t out_word;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  int miscompares = 0;
  int n_compared = 0;
  int sent = 0;
  logic style = 1'b0;
  logic stall = 1'b1;
  logic rd_pend = 1'b0;
  logic [15:0] seed = 16'h0029;
  logic [15:0] rs = 16'h0029;
  vtlb_pkg::vtlb_word_t wq[$];
  logic [31:0] rq[$];
  vtlb_pkg::vtlb_word_t exp_w;
  logic [31:0] exp_r;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  initial forever #4 ref_clk_i = ~ref_clk_i;

  vtlb_top vtlb_top_i (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .embedded_timing_select_i(emb), .processing_enable_i(proc), .rate_select_i(rate),
    .bus_width_select_i(width), .video_processing_select_i(vproc),
    .async_serial_mode_i(asy), .src_valid_i(src_valid), .src_ready_o(src_ready),
    .frame_blank_i(fb), .line_blank_i(lb), .field_i(fl), .upper_bus_i(up),
    .lower_bus_i(lo), .out_valid_o(out_valid), .out_ready_i(out_ready),
    .out_word_o(out_word), .lower_bus_enable_o(lb_en), .flywheel_external_o(fw_ext),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata));

  vtlb_src_model vtlb_src_model_i (
    .ref_clk_i(ref_clk_i), .ready_i(src_ready), .valid_o(src_valid), .stuck_o(stuck),
    .frame_blank_o(fb), .line_blank_o(lb), .field_o(fl), .upper_o(up), .lower_o(lo));

  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up

  // watcher: takes the oldest note whenever a word or read data shows
  always @(posedge ref_clk_i) begin
    // each note is taken once; a word with no note meets an unknown
    if (out_valid && out_ready) begin
      exp_w = 'x;
      if (wq.size() != 0) exp_w = wq.pop_front();
      `CHK(out_word.lower, exp_w.lower)
      `CHK(out_word, exp_w)
    end
    if (rd_pend) begin
      exp_r = 'x;
      if (rq.size() != 0) exp_r = rq.pop_front();
      `CHK(rdata, exp_r)
    end
    rd_pend <= rd;
    rs <= lfsr(rs);
    // sink stalls at random so the buffer sees back-pressure
    out_ready <= !stall && rs[0];
    if (stuck) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    @(posedge ref_clk_i);
  endtask : reg_rd

  // pins pass a filter, so give them time before any traffic
  task automatic set_mode(input logic [5:0] m);
    {emb, proc, rate, width, vproc, asy} <= m;
    repeat (10) @(posedge ref_clk_i);
    `CHK(lb_en, m[2] && !m[0])
    `CHK(fw_ext, !m[5])
  endtask : set_mode

  task automatic push_word();
    vtlb_pkg::vtlb_word_t e;
    logic [15:0] r;
    seed = lfsr(seed);
    r = seed;
    e.upper = r[9:0];
    e.lower = (width && !asy) ? r[15:6] : 10'h000;
    e.lb_mode = !(width && !asy) ? vtlb_pkg::VTLB_LB_UNUSED :
                vproc ? vtlb_pkg::VTLB_LB_CHROMA : vtlb_pkg::VTLB_LB_RAW;
    e.v_flag = !emb && proc && r[0];
    e.h_flag = !emb && proc && r[1];
    e.f_flag = !emb && proc && r[2];
    e.ext_timing = !emb;
    e.blank_style = style;
    wq.push_back(e);
    sent++;
    vtlb_src_model_i.send(r[0], r[1], r[2], r[9:0], r[15:6]);
  endtask : push_word

  task automatic drain();
    int n;
    n = 0;
    while (wq.size() != 0 && n < 200) begin
      n++;
      @(posedge ref_clk_i);
    end
    if (n >= 200) begin
      miscompares++;
      wrap_up();
    end
  endtask : drain

  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    reg_rd(vtlb_pkg::REG_CFG, 32'h0);
    reg_wr(8'h0C, 32'hFFFF_FFFF);
    reg_rd(8'h0C, 32'h0);
    stall <= 1'b0;
    // every pin combination, style flipped halfway
    for (int i = 0; i < 64; i++) begin
      set_mode(i[5:0]);
      if (i == 32) begin
        reg_wr(vtlb_pkg::REG_CFG, 32'hFFFF_FFFF);
        style = 1'b1;
        reg_rd(vtlb_pkg::REG_CFG, 32'h1);
      end
      repeat (3) push_word();
      vtlb_src_model_i.idle();
      drain();
    end
    // fill the buffer with the sink stalled, then offer a third word
    set_mode(6'h16);
    stall <= 1'b1;
    repeat (2) push_word();
    vtlb_src_model_i.idle();
    repeat (2) @(posedge ref_clk_i);
    `CHK(src_ready, 1'b0)
    reg_rd(vtlb_pkg::REG_STATUS, {21'h0, 1'b0, 1'b1, 3'b010, 6'h16});
    fork
      push_word();
      begin
        repeat (6) @(posedge ref_clk_i);
        stall <= 1'b0;
      end
    join
    vtlb_src_model_i.idle();
    drain();
    reg_rd(vtlb_pkg::REG_COUNT, 32'(sent));
    reg_wr(vtlb_pkg::REG_COUNT, 32'h0);
    reg_rd(vtlb_pkg::REG_COUNT, 32'h0);
    // mid-run reset: outputs and the style bit fall back to reset values
    reset_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    `CHK({src_ready, out_valid, lb_en, fw_ext}, 4'b1000)
    reg_rd(vtlb_pkg::REG_CFG, 32'h0);
    wrap_up();
  end
endmodule : test_vtlb

// ### dv/vtlb_src_model.sv
// behavioural video source that offers one word at a time to the pixel port
`timescale 1ns/1ps
module vtlb_src_model (
  // clock
  input wire logic ref_clk_i,
  // handshake
  input wire logic ready_i,
  output logic valid_o = 1'b0,
  output logic stuck_o = 1'b0,
  // timing levels and lanes
  output logic frame_blank_o = 1'b0,
  output logic line_blank_o = 1'b0,
  output logic field_o = 1'b0,
  output logic [9:0] upper_o = 10'h000,
  output logic [9:0] lower_o = 10'h000
);
  // offer a word and hold it unchanged until the edge that sees ready
  task automatic send(input logic fb, input logic lb, input logic fl,
                      input logic [9:0] up, input logic [9:0] lo);
    int n;
    n = 0;
    valid_o <= 1'b1;
    frame_blank_o <= fb;
    line_blank_o <= lb;
    field_o <= fl;
    upper_o <= up;
    lower_o <= lo;
    @(posedge ref_clk_i);
    while (!ready_i && n < 200) begin
      n++;
      @(posedge ref_clk_i);
    end
    // a refusal that never ends is flagged, not waited on forever
    if (n >= 200) stuck_o <= 1'b1;
  endtask : send

  // released lanes show the inverse, so stale data cannot look right
  task automatic idle();
    valid_o <= 1'b0;
    upper_o <= ~upper_o;
    lower_o <= ~lower_o;
  endtask : idle
endmodule : vtlb_src_model

// ### src/vtlb_fifo.sv
// small shift buffer whose head entry and flags all come from flip-flops
`timescale 1ns/1ps
module vtlb_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic ready;
    logic valid;
  } vtlb_fifo_st_t;

  vtlb_fifo_st_t st_q;
  vtlb_fifo_st_t st_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push;
  logic pop;

  if (DEPTH < 2) begin : g_chk
    $error("vtlb_fifo needs two entries or more");
  end

  assign push = in_valid_i && st_q.ready;
  assign pop = st_q.valid && out_ready_i;

  // flags are computed ahead so the ports come straight from flops
  always_comb begin
    st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
    st_d.ready = (st_d.cnt != FULL);
    st_d.valid = (st_d.cnt != '0);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= '{cnt: '0, ready: 1'b1, valid: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // entry 0 is the head; a pop shifts everyone down by one
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge ref_clk_i) begin
      if (push && (CW'(i) == (pop ? st_q.cnt - CW'(1) : st_q.cnt))) begin
        mem_q[i] <= in_data_i;
      end else if (pop) begin
        mem_q[i] <= (i < DEPTH - 1) ? mem_q[(i < DEPTH - 1) ? i + 1 : i] : mem_q[i];
      end
    end
  end

  assign in_ready_o = st_q.ready;
  assign out_valid_o = st_q.valid;
  assign out_data_o = mem_q[0];
endmodule : vtlb_fifo

// ### src/vtlb_pkg.sv
// constants, types and the decode function shared by the video timing input block
// What this block does
// - external timing plus processing enable: frame blank high sets every vertical flag
// - frame blank is ignored whenever embedded timing is selected
// - external timing plus processing enable: line blank high sets every horizontal flag
// - line blank style is a host-writable configuration register bit
// - lower bus bit nine is most significant, bit zero least
// - 20-bit, video processing on, async serial off: lower bus carries chroma
// - 20-bit, video processing off, async serial off: lower bus passes raw
// - 10-bit mode at either rate: lower bus unused, inputs high impedance
// - 20-bit with async serial mode: lower bus unused, high impedance
// - embedded timing deselected: flywheel locks to external timing inputs
// - external timing plus processing enable: field input high sets field flag
package vtlb_pkg;
  localparam int LANE_W = 10;
  localparam int CTRL_W = 6;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BUF_DEPTH = 2;
  // register offsets
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  // field positions and reset values
  localparam int CFG_STYLE_BIT = 0;
  localparam logic CFG_STYLE_RESET = 1'h0;
  localparam int STAT_CTRL_LSB = 0;
  localparam int STAT_MODE_LSB = 6;
  localparam int STAT_VALID_BIT = 9;
  localparam int STAT_READY_BIT = 10;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

  // lower bus use, one-hot
  typedef enum logic [2:0] {
    VTLB_LB_UNUSED = 3'b001,
    VTLB_LB_CHROMA = 3'b010,
    VTLB_LB_RAW = 3'b100
  } vtlb_lb_mode_t;

  // mode pins; rate high means standard definition, width high means 20-bit
  typedef struct packed {
    logic embedded_timing_select;
    logic processing_enable;
    logic rate_select;
    logic bus_width_select;
    logic video_processing_select;
    logic async_serial_mode;
  } vtlb_ctrl_t;

  // one sampled pixel word with its timing flags
  typedef struct packed {
    logic [LANE_W-1:0] upper;
    logic [LANE_W-1:0] lower;
    vtlb_lb_mode_t lb_mode;
    logic v_flag;
    logic h_flag;
    logic f_flag;
    logic ext_timing;
    logic blank_style;
  } vtlb_word_t;

  // whole register state of the top module
  typedef struct packed {
    logic style;
    vtlb_lb_mode_t lb_mode;
    logic lb_en;
    logic ext;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] words;
  } vtlb_state_t;

  // which way the lower bus is used for a given mode
  function automatic vtlb_lb_mode_t vtlb_lb_decode(input vtlb_ctrl_t c);
    vtlb_lb_mode_t m;
    m = VTLB_LB_UNUSED;
    if (c.bus_width_select && !c.async_serial_mode) begin
      m = c.video_processing_select ? VTLB_LB_CHROMA : VTLB_LB_RAW;
    end
    return m;
  endfunction : vtlb_lb_decode
endpackage : vtlb_pkg

// ### src/vtlb_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module vtlb_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // pins in, settled levels out
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } vtlb_sync_st_t;

  vtlb_sync_st_t st_q;
  vtlb_sync_st_t st_d;

  if (WIDTH < 1) begin : g_chk
    $error("vtlb_sync needs at least one bit");
  end

  // stage one feeds stage two only; filter looks at two and three
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule : vtlb_sync

// ### src/vtlb_top.sv
// video timing flag insertion and lower data bus steering behind the parallel input port
`timescale 1ns/1ps
module vtlb_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // mode pins, not synchronous to the parallel clock
  input wire logic embedded_timing_select_i,
  input wire logic processing_enable_i,
  input wire logic rate_select_i,
  input wire logic bus_width_select_i,
  input wire logic video_processing_select_i,
  input wire logic async_serial_mode_i,
  // pixel stream from the video source, on the parallel clock
  input wire logic src_valid_i,
  output logic src_ready_o,
  input wire logic frame_blank_i,
  input wire logic line_blank_i,
  input wire logic field_i,
  input wire logic [vtlb_pkg::LANE_W-1:0] upper_bus_i,
  input wire logic [vtlb_pkg::LANE_W-1:0] lower_bus_i,
  // flagged words toward the serializer
  output logic out_valid_o,
  input wire logic out_ready_i,
  output vtlb_pkg::vtlb_word_t out_word_o,
  // mode indications
  output logic lower_bus_enable_o,
  output logic flywheel_external_o,
  // register port
  input wire logic [vtlb_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [vtlb_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [vtlb_pkg::DATA_W-1:0] reg_rdata_o
);
  localparam int WORD_W = $bits(vtlb_pkg::vtlb_word_t);

  vtlb_pkg::vtlb_state_t st_q;
  vtlb_pkg::vtlb_state_t st_d;
  vtlb_pkg::vtlb_ctrl_t ctrl_pins;
  vtlb_pkg::vtlb_ctrl_t ctrl;
  vtlb_pkg::vtlb_lb_mode_t lb_dec;
  vtlb_pkg::vtlb_word_t in_word;
  logic ext_active;
  logic fifo_ready;
  logic push;
  logic [WORD_W-1:0] head_bits;

  // mode pins travel through the three-stage filter as one group
  assign ctrl_pins = '{
    embedded_timing_select: embedded_timing_select_i,
    processing_enable: processing_enable_i,
    rate_select: rate_select_i,
    bus_width_select: bus_width_select_i,
    video_processing_select: video_processing_select_i,
    async_serial_mode: async_serial_mode_i
  };

  vtlb_sync #(
    .WIDTH(vtlb_pkg::CTRL_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .pin_i(ctrl_pins),
    .level_o(ctrl)
  );

  // external flags count only with embedded timing off and processing on
  assign ext_active = !ctrl.embedded_timing_select && ctrl.processing_enable;
  assign lb_dec = vtlb_pkg::vtlb_lb_decode(ctrl);

  // build the word straight from the pins; the buffer write is the sampling edge
  always_comb begin
    in_word = '0;
    in_word.upper = upper_bus_i;
    in_word.lb_mode = lb_dec;
    in_word.v_flag = ext_active && frame_blank_i;
    in_word.h_flag = ext_active && line_blank_i;
    in_word.f_flag = ext_active && field_i;
    in_word.ext_timing = !ctrl.embedded_timing_select;
    // the style tells the flywheel which blanking convention the source follows
    in_word.blank_style = st_q.style;
    case (lb_dec)
      vtlb_pkg::VTLB_LB_CHROMA: in_word.lower = lower_bus_i;
      vtlb_pkg::VTLB_LB_RAW: in_word.lower = lower_bus_i;
      vtlb_pkg::VTLB_LB_UNUSED: in_word.lower = '0;
      default: in_word.lower = '0;
    endcase
  end

  assign push = src_valid_i && fifo_ready;

  // two entries absorb a receiver stall without dropping a word
  vtlb_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(vtlb_pkg::BUF_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .in_valid_i(src_valid_i),
    .in_data_i(in_word),
    .in_ready_o(fifo_ready),
    .out_valid_o(out_valid_o),
    .out_data_o(head_bits),
    .out_ready_i(out_ready_i)
  );

  assign out_word_o = vtlb_pkg::vtlb_word_t'(head_bits);
  assign src_ready_o = fifo_ready;

  // next state: mode tracking, register writes, read data and word count
  always_comb begin
    st_d = st_q;
    st_d.lb_mode = lb_dec;
    // unused lower inputs stay disabled, which the pads show as high impedance
    st_d.lb_en = (lb_dec != vtlb_pkg::VTLB_LB_UNUSED);
    st_d.ext = !ctrl.embedded_timing_select;
    st_d.rdata = '0;
    if (push) begin
      st_d.words = st_q.words + vtlb_pkg::COUNT_ONE;
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        vtlb_pkg::REG_CFG: st_d.style = reg_wdata_i[vtlb_pkg::CFG_STYLE_BIT];
        // a clear landing with a push keeps that push counted
        vtlb_pkg::REG_COUNT: st_d.words = push ? vtlb_pkg::COUNT_ONE : '0;
        default: st_d.style = st_q.style;
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        vtlb_pkg::REG_CFG: st_d.rdata[vtlb_pkg::CFG_STYLE_BIT] = st_q.style;
        vtlb_pkg::REG_STATUS: begin
          st_d.rdata[vtlb_pkg::STAT_CTRL_LSB +: vtlb_pkg::CTRL_W] = ctrl;
          st_d.rdata[vtlb_pkg::STAT_MODE_LSB +: $bits(vtlb_pkg::vtlb_lb_mode_t)] = st_q.lb_mode;
          st_d.rdata[vtlb_pkg::STAT_VALID_BIT] = out_valid_o;
          st_d.rdata[vtlb_pkg::STAT_READY_BIT] = fifo_ready;
        end
        vtlb_pkg::REG_COUNT: st_d.rdata = st_q.words;
        default: st_d.rdata = '0;
      endcase
    end
  end

  // all control state; reset gives style 0, lower bus off, embedded timing
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_q <= '{
        style: vtlb_pkg::CFG_STYLE_RESET,
        lb_mode: vtlb_pkg::VTLB_LB_UNUSED,
        lb_en: 1'b0,
        ext: 1'b0,
        rdata: '0,
        words: '0
      };
    end else begin
      st_q <= st_d;
    end
  end

  assign lower_bus_enable_o = st_q.lb_en;
  assign flywheel_external_o = st_q.ext;
  assign reg_rdata_o = st_q.rdata;

  // checks on the design's own outputs
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // a word written into an empty buffer is the head on the next edge
  sequence s_first_push;
    !out_valid_o && push;
  endsequence

  sequence s_cfg_write;
    reg_wr_i && reg_addr_i == vtlb_pkg::REG_CFG;
  endsequence

  sequence s_cfg_read;
    reg_rd_i && reg_addr_i == vtlb_pkg::REG_CFG;
  endsequence

  property p_flag_follows(logic cause, logic flag);
    s_first_push ##0 cause |=> flag;
  endproperty

  a_vflag_frame_blank: assert property (
    s_first_push |=> out_word_o.v_flag == $past(ext_active && frame_blank_i)
  ) else $error("vertical flag does not follow frame blank");

  a_embedded_ignores_pins: assert property (
    p_flag_follows(ctrl.embedded_timing_select,
      !out_word_o.v_flag && !out_word_o.h_flag && !out_word_o.f_flag)
  ) else $error("timing pins used while embedded timing selected");

  a_hflag_line_blank: assert property (
    p_flag_follows(ext_active && line_blank_i, out_word_o.h_flag)
  ) else $error("horizontal flag missing while line blank high");

  a_field_flag_set: assert property (
    s_first_push |=> out_word_o.f_flag == $past(ext_active && field_i)
  ) else $error("field flag does not follow field input");

  a_style_reg_readback: assert property (
    s_cfg_write ##1 s_cfg_read |=>
      reg_rdata_o[vtlb_pkg::CFG_STYLE_BIT] == $past(reg_wdata_i[vtlb_pkg::CFG_STYLE_BIT], 2)
  ) else $error("line blank style did not read back");

  a_lower_chroma_taken: assert property (
    s_first_push ##0 lb_dec == vtlb_pkg::VTLB_LB_CHROMA |=>
      out_word_o.lower == $past(lower_bus_i) && out_word_o.lb_mode == vtlb_pkg::VTLB_LB_CHROMA
  ) else $error("chroma not taken from lower bus");

  a_lower_raw_pass: assert property (
    s_first_push ##0 lb_dec == vtlb_pkg::VTLB_LB_RAW |=>
      out_word_o.lower == $past(lower_bus_i) && out_word_o.lb_mode == vtlb_pkg::VTLB_LB_RAW
  ) else $error("raw lower word not passed through");

  a_lower_unused_zero: assert property (
    s_first_push ##0 (!ctrl.bus_width_select || ctrl.async_serial_mode) |=>
      out_word_o.lower == '0 && !lower_bus_enable_o
  ) else $error("lower bus used in a mode that leaves it idle");

  a_flywheel_external: assert property (
    (!embedded_timing_select_i)[*6] |-> ##[0:3] flywheel_external_o
  ) else $error("flywheel not switched to external timing");

  a_stall_holds_word: assert property (
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_word_o)
  ) else $error("stalled word changed or vanished");

  // a push that lands while the external flags are live
  sequence s_ext_push;
    s_first_push ##0 ext_active;
  endsequence

  // a push that lands while the external flags are masked
  sequence s_emb_push;
    s_first_push ##0 !ext_active;
  endsequence

  // a read strobe aimed at the count register
  sequence s_count_read;
    reg_rd_i && reg_addr_i == vtlb_pkg::REG_COUNT;
  endsequence

  // a count clear with no push beside it, so zero is the only answer
  sequence s_count_clear;
    reg_wr_i && reg_addr_i == vtlb_pkg::REG_COUNT && !push;
  endsequence

  // a read strobe aimed at the status register
  sequence s_status_read;
    reg_rd_i && reg_addr_i == vtlb_pkg::REG_STATUS;
  endsequence

  // a read strobe aimed at no register at all
  sequence s_hole_read;
    reg_rd_i && reg_addr_i != vtlb_pkg::REG_CFG && reg_addr_i != vtlb_pkg::REG_STATUS &&
      reg_addr_i != vtlb_pkg::REG_COUNT;
  endsequence

  // both buffer entries held and the sink refuses the head
  sequence s_full_stall;
    !src_ready_o && !out_ready_i;
  endsequence

  a_hflag_clear_low: assert property (
    s_ext_push ##0 !line_blank_i |=> !out_word_o.h_flag
  ) else $error("horizontal flag set while line blank low");

  a_vflag_silent_emb: assert property (
    s_emb_push |=> !out_word_o.v_flag
  ) else $error("vertical flag set without external timing");

  a_field_silent_emb: assert property (
    s_emb_push |=> !out_word_o.f_flag
  ) else $error("field flag set without external timing");

  a_upper_taken: assert property (
    s_first_push |=> out_word_o.upper == $past(upper_bus_i)
  ) else $error("upper lane not taken with its flags");

  // the two end bits are enough to catch a reversed lane
  a_lower_bit_order: assert property (
    s_first_push ##0 lb_dec != vtlb_pkg::VTLB_LB_UNUSED |=>
      out_word_o.lower[vtlb_pkg::LANE_W-1] == $past(lower_bus_i[vtlb_pkg::LANE_W-1]) &&
      out_word_o.lower[0] == $past(lower_bus_i[0])
  ) else $error("lower lane bits reordered");

  a_ext_timing_bit: assert property (
    s_first_push |=> out_word_o.ext_timing == $past(!ctrl.embedded_timing_select)
  ) else $error("timing source bit wrong in word");

  a_style_in_word: assert property (
    s_first_push |=> out_word_o.blank_style == $past(st_q.style)
  ) else $error("line blank style not carried in word");

  a_mode_in_word: assert property (
    s_first_push |=> out_word_o.lb_mode == $past(lb_dec)
  ) else $error("lower bus use not carried in word");

  a_chroma_bus_on: assert property (
    s_first_push ##0 lb_dec == vtlb_pkg::VTLB_LB_CHROMA |=> lower_bus_enable_o
  ) else $error("lower bus off while chroma is taken");

  a_raw_bus_on: assert property (
    s_first_push ##0 lb_dec == vtlb_pkg::VTLB_LB_RAW |=> lower_bus_enable_o
  ) else $error("lower bus off while raw words pass");

  // registered levels trail the filtered pins by exactly one edge
  a_enable_follows: assert property (
    !reset_i |=> lower_bus_enable_o == $past(lb_dec != vtlb_pkg::VTLB_LB_UNUSED)
  ) else $error("lower bus enable does not track the mode");

  a_flywheel_follows: assert property (
    !reset_i |=> flywheel_external_o == $past(!ctrl.embedded_timing_select)
  ) else $error("flywheel source does not track the select");

  a_read_one_cycle: assert property (
    !reg_rd_i |=> reg_rdata_o == '0
  ) else $error("read data outlived its cycle");

  a_hole_reads_zero: assert property (
    s_hole_read |=> reg_rdata_o == '0
  ) else $error("unmapped read returned data");

  a_count_clears: assert property (
    s_count_clear ##1 s_count_read |=> reg_rdata_o == '0
  ) else $error("count did not clear on write");

  a_status_flags: assert property (
    s_status_read |=> reg_rdata_o[vtlb_pkg::STAT_READY_BIT] == $past(src_ready_o) &&
      reg_rdata_o[vtlb_pkg::STAT_VALID_BIT] == $past(out_valid_o)
  ) else $error("status flags do not match the buffer");

  // a full buffer under stall must neither take nor lose a word
  a_full_refuses: assert property (
    s_full_stall |=> !src_ready_o && out_valid_o
  ) else $error("full buffer changed under stall");

  a_pop_frees_slot: assert property (
    out_valid_o && out_ready_i && !src_ready_o |=> src_ready_o
  ) else $error("buffer stays full after a word left");
endmodule : vtlb_top
